// ===== rtl/lcfg_config_top.sv
// Transceiver and power management configuration commands behind the serial port.
//
// Overview of operation
// - Transceiver config written with code 0x50, read with 0x90, from upper byte.
// - Transceiver bits held until next write or reset; responses to 0x50 and 0x90 show them.
// - Slew 00 shaped 20 kBaud, 01 10.4 kBaud, 1x fast unshaped.
// - Monitor bit 0 routes LIN data to receive pin, 1 routes satellite signal.
// - Channel field bits 4:3 selects satellite channel one to four.
// - In monitor mode receive pin follows selected channel threshold state.
// - Power config written with code 0x51, read with 0x91.
// - Power settings held until next write or reset; responses show state.
// - Thermal or over-current shutdown can turn a supply off while enabled.
// - Switch fault cleared by reset or by writing reserve field 00.
// - Reserve field reset by sleep reset; all else only by internal reset.
// - Reserve 00 both off, 01 charge only, 10 discharge only.
// - Bit 7 of response shows boost above about 80 percent of target.
// - Bit 6 of response shows charge or discharge switch fault.
// - Bit 5 sync supply, bit 4 boost, bit 2 buck enable.
// - Response bit 12 makes the whole frame odd parity.
// - Response bits 11:10 are 11 and bits 9:8 are 10.
// - Granted requests copy opcode into bits 14:13, 01 write, 10 read.
`timescale 1ns/1ns
`default_nettype none

module lcfg_config_top (
   input  wire logic       i_core_clk,
   input  wire logic       i_reset,
   input  wire logic       i_sleep_reset,
   input  wire logic       i_spi_cs_n,
   input  wire logic       i_spi_sck,
   input  wire logic       i_spi_mosi,
   output logic            o_spi_miso,
   input  wire logic       i_lin_rx_data,
   input  wire logic [3:0] i_sat_threshold,
   input  wire logic       i_boost_above_threshold,
   input  wire logic       i_switch_fault_event,
   input  wire logic       i_sync_shutdown,
   input  wire logic       i_boost_shutdown,
   input  wire logic       i_buck_shutdown,
   output logic            o_rxd,
   output logic [1:0]      o_slew_select,
   output logic            o_wave_shaping_off,
   output logic            o_lin_rate_10k4,
   output logic            o_sync_supply_on,
   output logic            o_boost_on,
   output logic            o_buck_on,
   output logic            o_charge_switch_on,
   output logic            o_discharge_switch_on
);

   // Stored settings and flags.
   logic [1:0]  slew_select_reg;
   logic [1:0]  monitor_channel_select_reg;
   logic        monitor_mode_reg;
   logic        sync_supply_on_reg;
   logic        boost_on_reg;
   logic        buck_on_reg;
   logic [1:0]  reserve_switch_control_reg;
   logic        switch_fault_flag_reg;
   logic [15:0] resp_reg;
   logic        rxd_reg;
   logic        sync_out_reg;
   logic        boost_out_reg;
   logic        buck_out_reg;
   logic        charge_out_reg;
   logic        discharge_out_reg;

   // Next values.
   logic [1:0]  slew_select_next;
   logic [1:0]  monitor_channel_select_next;
   logic        monitor_mode_next;
   logic        sync_supply_on_next;
   logic        boost_on_next;
   logic        buck_on_next;
   logic [1:0]  reserve_switch_control_next;
   logic        switch_fault_flag_next;
   logic [15:0] resp_next;
   logic        rxd_next;

   // Shift engine outputs.
   logic        frame_done;
   logic        frame_ok;
   logic [15:0] rx_word;
   lcfg_pkg::lcfg_cmd_e cmd;

   // The serial engine loads the stored response at select fall, so the
   // answer to one request is shifted out during the following frame.
   lcfg_spi_shift u_shift (
      .i_core_clk   (i_core_clk),
      .i_reset      (i_reset),
      .i_cs_n       (i_spi_cs_n),
      .i_sck        (i_spi_sck),
      .i_mosi       (i_spi_mosi),
      .i_tx_word    (resp_reg),
      .o_miso       (o_spi_miso),
      .o_frame_done (frame_done),
      .o_frame_ok   (frame_ok),
      .o_rx_word    (rx_word)
   );

   // Request fields; the lower byte is only used by writes.
   wire [7:0] req_code = rx_word[15:8];
   wire [7:0] req_data = rx_word[7:0];

   // Request decode from the code byte.
   // code decode
   always_comb begin
      if (!frame_ok) begin
         cmd = lcfg_pkg::LCFG_CMD_BAD_FRAME;
      end else begin
         case (req_code)
            lcfg_pkg::LCFG_CODE_LIN_WR: cmd = lcfg_pkg::LCFG_CMD_LIN_WR;
            lcfg_pkg::LCFG_CODE_LIN_RD: cmd = lcfg_pkg::LCFG_CMD_LIN_RD;
            lcfg_pkg::LCFG_CODE_PWR_WR: cmd = lcfg_pkg::LCFG_CMD_PWR_WR;
            lcfg_pkg::LCFG_CODE_PWR_RD: cmd = lcfg_pkg::LCFG_CMD_PWR_RD;
            default:                    cmd = lcfg_pkg::LCFG_CMD_UNKNOWN;
         endcase
      end
   end

   // Write strobes; a read never touches the stored settings.
   // read data ignored
   wire lin_write = frame_done & (cmd == lcfg_pkg::LCFG_CMD_LIN_WR);
   wire pwr_write = frame_done & (cmd == lcfg_pkg::LCFG_CMD_PWR_WR);

   // Only the documented bits of a write are stored.
   // don't-care bits ignored
   wire [1:0] wr_slew    = req_data[lcfg_pkg::LCFG_SLEW_LSB +: 2];
   wire [1:0] wr_chan    = req_data[lcfg_pkg::LCFG_CHAN_LSB +: 2];
   wire       wr_monitor = req_data[lcfg_pkg::LCFG_MONITOR_BIT];
   wire [1:0] wr_reserve = req_data[lcfg_pkg::LCFG_RESERVE_LSB +: 2];
   wire       wr_buck    = req_data[lcfg_pkg::LCFG_BUCK_BIT];
   wire       wr_boost   = req_data[lcfg_pkg::LCFG_BOOST_BIT];
   wire       wr_sync    = req_data[lcfg_pkg::LCFG_SYNC_BIT];

   // Transceiver settings change only on their own write.
   // hold until write
   always_comb begin
      slew_select_next            = slew_select_reg;
      monitor_channel_select_next = monitor_channel_select_reg;
      monitor_mode_next           = monitor_mode_reg;
      if (lin_write) begin
         slew_select_next            = wr_slew;
         monitor_channel_select_next = wr_chan;
         monitor_mode_next           = wr_monitor;
      end
   end

   // Supply enables change only on their own write.
   // hold until write
   always_comb begin
      sync_supply_on_next = sync_supply_on_reg;
      boost_on_next       = boost_on_reg;
      buck_on_next        = buck_on_reg;
      if (pwr_write) begin
         sync_supply_on_next = wr_sync;
         boost_on_next       = wr_boost;
         buck_on_next        = wr_buck;
      end
   end

   // The reserve field alone also falls back on a sleep reset. A write in
   // the same cycle as a sleep reset loses, since sleep means power down.
   // sleep reset
   always_comb begin
      reserve_switch_control_next = reserve_switch_control_reg;
      if (i_sleep_reset) begin
         reserve_switch_control_next = lcfg_pkg::LCFG_RESERVE_RST;
      end else if (pwr_write) begin
         reserve_switch_control_next = wr_reserve;
      end
   end

   // A fault event always wins over the clear, so no fault is lost.
   // fault flag
   wire fault_clear = pwr_write & (wr_reserve == lcfg_pkg::LCFG_RES_OFF);
   always_comb begin
      switch_fault_flag_next = switch_fault_flag_reg;
      if (i_switch_fault_event) begin
         switch_fault_flag_next = 1'b1;
      end else if (fault_clear) begin
         switch_fault_flag_next = 1'b0;
      end
   end

   // Data bytes for each response kind, built from the state that will be
   // in force after this frame.
   // power byte
   wire [7:0] pwr_byte = {i_boost_above_threshold,
                          switch_fault_flag_next,
                          sync_supply_on_next,
                          boost_on_next,
                          1'b0,
                          buck_on_next,
                          reserve_switch_control_next};

   wire [7:0] lin_byte = {2'h0,
                          monitor_mode_next,
                          monitor_channel_select_next,
                          1'b0,
                          slew_select_next};

   // Refused requests carry an error bit instead of data.
   wire [7:0] spi_err_byte = 8'h01 << lcfg_pkg::LCFG_SPI_ERR_BIT;
   wire [7:0] req_err_byte = 8'h01 << lcfg_pkg::LCFG_REQ_ERR_BIT;

   // Opcode and data selection for the response.
   // opcode copy
   logic [1:0] resp_op;
   logic [7:0] resp_data;
   always_comb begin
      case (cmd)
         lcfg_pkg::LCFG_CMD_LIN_WR: begin
            resp_op   = lcfg_pkg::LCFG_OP_WRITE;
            resp_data = lin_byte;
         end
         lcfg_pkg::LCFG_CMD_LIN_RD: begin
            resp_op   = lcfg_pkg::LCFG_OP_READ;
            resp_data = lin_byte;
         end
         lcfg_pkg::LCFG_CMD_PWR_WR: begin
            resp_op   = lcfg_pkg::LCFG_OP_WRITE;
            resp_data = pwr_byte;
         end
         lcfg_pkg::LCFG_CMD_PWR_RD: begin
            resp_op   = lcfg_pkg::LCFG_OP_READ;
            resp_data = pwr_byte;
         end
         lcfg_pkg::LCFG_CMD_BAD_FRAME: begin
            resp_op   = lcfg_pkg::LCFG_OP_NONE;
            resp_data = spi_err_byte;
         end
         default: begin
            resp_op   = lcfg_pkg::LCFG_OP_NONE;
            resp_data = req_err_byte;
         end
      endcase
   end

   // Header and parity; bit 15 is sent as zero.
   // fixed status
   wire [15:0] resp_body = {1'b0, resp_op, 1'b0,
                            lcfg_pkg::LCFG_STATUS,
                            lcfg_pkg::LCFG_EXCEPTION,
                            resp_data};
   wire resp_parity = ~(^resp_body);

   // The response only changes at the end of a frame.
   always_comb begin
      resp_next = resp_reg;
      if (frame_done) begin
         resp_next = {resp_body[15:13], resp_parity, resp_body[11:0]};
      end
   end

   // Receive pin source: LIN data or the chosen satellite threshold.
   // receive mux
   wire sat_level = i_sat_threshold[monitor_channel_select_reg];
   always_comb begin
      rxd_next = i_lin_rx_data;
      if (monitor_mode_reg) begin
         rxd_next = sat_level;
      end
   end

   // Switch drive from the reserve field. Code 11 is not a legal
   // setting, so both switches stay open rather than guessing one.
   // switch decode
   wire charge_sel    = (reserve_switch_control_reg == lcfg_pkg::LCFG_RES_CHARGE);
   wire discharge_sel = (reserve_switch_control_reg == lcfg_pkg::LCFG_RES_DISCHARGE);

   // Supplies stay off under a shutdown even though the enable is kept,
   // so software sees its setting while the hardware protects itself.
   // shutdown gating
   wire sync_drive  = sync_supply_on_reg & ~i_sync_shutdown;
   wire boost_drive = boost_on_reg & ~i_boost_shutdown;
   wire buck_drive  = buck_on_reg & ~i_buck_shutdown;

   // Settings registers; internal reset restores every default.
   // internal reset
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         slew_select_reg            <= lcfg_pkg::LCFG_SLEW_RST;
         monitor_channel_select_reg <= lcfg_pkg::LCFG_CHAN_RST;
         monitor_mode_reg           <= lcfg_pkg::LCFG_MONITOR_RST;
         sync_supply_on_reg         <= lcfg_pkg::LCFG_SYNC_RST;
         boost_on_reg               <= lcfg_pkg::LCFG_BOOST_RST;
         buck_on_reg                <= lcfg_pkg::LCFG_BUCK_RST;
      end else begin
         slew_select_reg            <= slew_select_next;
         monitor_channel_select_reg <= monitor_channel_select_next;
         monitor_mode_reg           <= monitor_mode_next;
         sync_supply_on_reg         <= sync_supply_on_next;
         boost_on_reg               <= boost_on_next;
         buck_on_reg                <= buck_on_next;
      end
   end

   // Reserve field, fault flag and response word.
   // reset clears fault
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         reserve_switch_control_reg <= lcfg_pkg::LCFG_RESERVE_RST;
         switch_fault_flag_reg      <= 1'b0;
         resp_reg                   <= lcfg_pkg::LCFG_RESP_RST;
      end else begin
         reserve_switch_control_reg <= reserve_switch_control_next;
         switch_fault_flag_reg      <= switch_fault_flag_next;
         resp_reg                   <= resp_next;
      end
   end

   // Output flops; reset drives rxd high and every supply and switch output off, so boost, buck and discharge reach their on defaults a cycle later.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         rxd_reg           <= 1'b1;
         sync_out_reg      <= 1'b0;
         boost_out_reg     <= 1'b0;
         buck_out_reg      <= 1'b0;
         charge_out_reg    <= 1'b0;
         discharge_out_reg <= 1'b0;
      end else begin
         rxd_reg           <= rxd_next;
         sync_out_reg      <= sync_drive;
         boost_out_reg     <= boost_drive;
         buck_out_reg      <= buck_drive;
         charge_out_reg    <= charge_sel;
         discharge_out_reg <= discharge_sel;
      end
   end

   // Slew control straight from the stored field.
   // slew decode
   assign o_slew_select      = slew_select_reg;
   assign o_wave_shaping_off = slew_select_reg[1];
   assign o_lin_rate_10k4    = (slew_select_reg == lcfg_pkg::LCFG_SLEW_10K4);

   // Remaining outputs.
   assign o_rxd                 = rxd_reg;
   assign o_sync_supply_on      = sync_out_reg;
   assign o_boost_on            = boost_out_reg;
   assign o_buck_on             = buck_out_reg;
   assign o_charge_switch_on    = charge_out_reg;
   assign o_discharge_switch_on = discharge_out_reg;

endmodule

`default_nettype wire

// ===== rtl/lcfg_pkg.sv
// Constants and types shared by the transceiver and supply configuration block.
package lcfg_pkg;

   // Frame length in serial clock pulses.
   localparam logic [4:0] LCFG_FRAME_LEN = 5'h10;

   // Command codes carried in the upper byte of a request.
   localparam logic [7:0] LCFG_CODE_LIN_WR = 8'h50;
   localparam logic [7:0] LCFG_CODE_LIN_RD = 8'h90;
   localparam logic [7:0] LCFG_CODE_PWR_WR = 8'h51;
   localparam logic [7:0] LCFG_CODE_PWR_RD = 8'h91;

   // Response header fields.
   localparam logic [1:0] LCFG_OP_WRITE    = 2'h1;
   localparam logic [1:0] LCFG_OP_READ     = 2'h2;
   localparam logic [1:0] LCFG_OP_NONE     = 2'h0;
   localparam logic [1:0] LCFG_STATUS      = 2'h3;
   localparam logic [1:0] LCFG_EXCEPTION   = 2'h2;

   // Error bits in the data byte of a refused request.
   localparam int LCFG_SPI_ERR_BIT = 2;
   localparam int LCFG_REQ_ERR_BIT = 1;

   // Field positions of transceiver_config.
   localparam int LCFG_SLEW_LSB    = 0;
   localparam int LCFG_CHAN_LSB    = 3;
   localparam int LCFG_MONITOR_BIT = 5;

   // Field positions of power_management_control.
   localparam int LCFG_RESERVE_LSB = 0;
   localparam int LCFG_BUCK_BIT    = 2;
   localparam int LCFG_BOOST_BIT   = 4;
   localparam int LCFG_SYNC_BIT    = 5;
   localparam int LCFG_FAULT_BIT   = 6;
   localparam int LCFG_GOOD_BIT    = 7;

   // Values after reset.
   localparam logic [1:0] LCFG_SLEW_RST    = 2'h0;
   localparam logic [1:0] LCFG_CHAN_RST    = 2'h0;
   localparam logic       LCFG_MONITOR_RST = 1'b0;
   localparam logic       LCFG_SYNC_RST    = 1'b0;
   localparam logic       LCFG_BOOST_RST   = 1'b1;
   localparam logic       LCFG_BUCK_RST    = 1'b1;
   localparam logic [1:0] LCFG_RESERVE_RST = 2'h2;
   localparam logic [15:0] LCFG_RESP_RST   = 16'h0000;

   // Energy-reserve switch codes.
   localparam logic [1:0] LCFG_RES_OFF       = 2'h0;
   localparam logic [1:0] LCFG_RES_CHARGE    = 2'h1;
   localparam logic [1:0] LCFG_RES_DISCHARGE = 2'h2;

   // Slew select codes.
   localparam logic [1:0] LCFG_SLEW_20K  = 2'h0;
   localparam logic [1:0] LCFG_SLEW_10K4 = 2'h1;

   // Decoded request kinds.
   typedef enum logic [2:0] {
      LCFG_CMD_LIN_WR,
      LCFG_CMD_LIN_RD,
      LCFG_CMD_PWR_WR,
      LCFG_CMD_PWR_RD,
      LCFG_CMD_UNKNOWN,
      LCFG_CMD_BAD_FRAME
   } lcfg_cmd_e;

endpackage

// ===== rtl/lcfg_spi_shift.sv
// Serial shift engine: collects one request frame and shifts out one response.
`timescale 1ns/1ns
`default_nettype none

module lcfg_spi_shift (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_cs_n,
   input  wire logic        i_sck,
   input  wire logic        i_mosi,
   input  wire logic [15:0] i_tx_word,
   output logic             o_miso,
   output logic             o_frame_done,
   output logic             o_frame_ok,
   output logic [15:0]      o_rx_word
);

   logic        sck_reg;
   logic        cs_n_reg;
   logic [4:0]  count_reg;
   logic [15:0] rx_reg;
   logic [15:0] tx_reg;
   logic        done_reg;

   // Edges of the serial clock and select, seen on the core clock.
   wire sck_rise = i_sck & ~sck_reg & ~i_cs_n;
   wire sck_fall = ~i_sck & sck_reg & ~i_cs_n;
   wire cs_fall  = ~i_cs_n & cs_n_reg;
   wire cs_rise  = i_cs_n & ~cs_n_reg;

   // Count saturates so a long frame is never mistaken for a good one.
   wire [4:0] count_next = (count_reg == 5'h1F) ? count_reg : count_reg + 5'h01;

   // Capture on rising edges, shift the response on falling edges.
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         sck_reg   <= 1'b0;
         cs_n_reg  <= 1'b1;
         count_reg <= 5'h00;
         rx_reg    <= 16'h0000;
         tx_reg    <= 16'h0000;
         done_reg  <= 1'b0;
      end else begin
         sck_reg  <= i_sck;
         cs_n_reg <= i_cs_n;
         done_reg <= cs_rise;
         if (cs_fall) begin
            count_reg <= 5'h00;
            tx_reg    <= i_tx_word;
         end else if (sck_rise) begin
            count_reg <= count_next;
            rx_reg    <= {rx_reg[14:0], i_mosi};
         end else if (sck_fall) begin
            tx_reg <= {tx_reg[14:0], 1'b0};
         end
      end
   end

   assign o_miso       = tx_reg[15];
   assign o_frame_done = done_reg;
   assign o_frame_ok   = (count_reg == lcfg_pkg::LCFG_FRAME_LEN);
   assign o_rx_word    = rx_reg;

endmodule

`default_nettype wire

// ===== bench/lcfg_host_model.sv
// Host side serial master model that runs one request frame at a time.
`timescale 1ns/1ns
`default_nettype none

module lcfg_host_model (
   input  wire logic i_core_clk,
   input  wire logic i_miso,
   output logic      o_cs_n,
   output logic      o_sck,
   output logic      o_mosi
);
   // The serial clock idles low and only moves inside a frame.
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_mosi = 1'b0;
   end

   // Each serial phase lasts at least two core cycles, so the device sees every edge.
   // codes sent
   task automatic xfer(input logic [15:0] req, input int n, output logic [15:0] resp);
      resp = 16'h0000;
      o_cs_n = 1'b0;
      repeat (2) @(negedge i_core_clk);
      for (int i = 15; i > 15 - n; i--) begin
         o_mosi = req[i];
         repeat (2) @(negedge i_core_clk);
         resp = {resp[14:0], i_miso};
         o_sck = 1'b1;
         repeat (3) @(negedge i_core_clk);
         o_sck = 1'b0;
         repeat (3) @(negedge i_core_clk);
      end
      // The released data line flips so that a stale bit never looks valid.
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      repeat (6) @(negedge i_core_clk);
   endtask
endmodule
`default_nettype wire

// ===== bench/lcfg_config_top_asserts.sv
// Concurrent checks on the configuration block ports.
`timescale 1ns/1ns
`default_nettype none

module lcfg_config_checker (
   input wire logic       i_core_clk,
   input wire logic       i_reset,
   input wire logic       i_sleep_reset,
   input wire logic       i_spi_cs_n,
   input wire logic       i_lin_rx_data,
   input wire logic [3:0] i_sat_threshold,
   input wire logic       i_sync_shutdown,
   input wire logic       i_boost_shutdown,
   input wire logic       i_buck_shutdown,
   input wire logic       o_rxd,
   input wire logic [1:0] o_slew_select,
   input wire logic       o_wave_shaping_off,
   input wire logic       o_lin_rate_10k4,
   input wire logic       o_sync_supply_on,
   input wire logic       o_boost_on,
   input wire logic       o_buck_on,
   input wire logic       o_charge_switch_on,
   input wire logic       o_discharge_switch_on
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   // Switch and slew decoding, shutdown overrides and receive routing.
   a_switch_exclusive: assert property (!(o_charge_switch_on && o_discharge_switch_on))
      else $error("charge and discharge switches on together");
   a_wave_shaping: assert property (o_wave_shaping_off == o_slew_select[1])
      else $error("wave shaping output disagrees with slew field");
   a_rate_slow: assert property (o_lin_rate_10k4 == (o_slew_select == 2'h1))
      else $error("slow rate output disagrees with slew field");
   a_sync_shutdown: assert property (i_sync_shutdown |=> !o_sync_supply_on)
      else $error("sync supply stayed on in shutdown");
   a_boost_shutdown: assert property (i_boost_shutdown |=> !o_boost_on)
      else $error("boost stayed on in shutdown");
   a_buck_shutdown: assert property (i_buck_shutdown |=> !o_buck_on)
      else $error("buck stayed on in shutdown");
   a_sleep_reserve: assert property (i_sleep_reset |-> ##[1:3] (o_discharge_switch_on && !o_charge_switch_on))
      else $error("sleep reset did not restore discharge switch");
   a_slew_held: assert property (!i_spi_cs_n [*2] |=> $stable(o_slew_select))
      else $error("slew field changed inside a frame");
   // The first edge after reset still shows the recessive reset level, not a sampled source.
   a_rxd_source: assert property ($past(i_reset) || o_rxd == $past(i_lin_rx_data)
      || (o_rxd ? |$past(i_sat_threshold) : !(&$past(i_sat_threshold))))
      else $error("receive pin matches no source");

   // Main scenarios reached.
   c_charge: cover property (o_charge_switch_on);
   c_sleep: cover property (i_sleep_reset ##1 o_discharge_switch_on);
   c_fast: cover property (o_slew_select == 2'h3);
endmodule

bind lcfg_config_top lcfg_config_checker u_chk (
   .i_core_clk(i_core_clk), .i_reset(i_reset), .i_sleep_reset(i_sleep_reset), .i_spi_cs_n(i_spi_cs_n),
   .i_lin_rx_data(i_lin_rx_data), .i_sat_threshold(i_sat_threshold), .i_sync_shutdown(i_sync_shutdown),
   .i_boost_shutdown(i_boost_shutdown), .i_buck_shutdown(i_buck_shutdown), .o_rxd(o_rxd),
   .o_slew_select(o_slew_select), .o_wave_shaping_off(o_wave_shaping_off), .o_lin_rate_10k4(o_lin_rate_10k4),
   .o_sync_supply_on(o_sync_supply_on), .o_boost_on(o_boost_on), .o_buck_on(o_buck_on),
   .o_charge_switch_on(o_charge_switch_on), .o_discharge_switch_on(o_discharge_switch_on));
`default_nettype wire

// ===== bench/lcfg_config_top_tb.sv
// Self-checking bench for the configuration block with a reference model.
`timescale 1ns/1ns
`default_nettype none

module lcfg_config_top_tb;
   int          failures, n_tests, cycles, seed, slew, chan, mon, sync, boost_good_flag, bck, res, flt;
   logic [15:0] exp_resp, resp;
   logic [7:0]  d;
   logic [3:0]  sat;
   logic [1:0]  slew_o;
   logic        clk, rst, slp, lin, bgood, fev, sds, bos, bus;
   logic        rxd, wave, rate, sync_o, boost_o, buck_o, chg_o, dis_o;
   wire         cs_n, sck, mosi, miso;

   lcfg_host_model host (.i_core_clk(clk), .i_miso(miso), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi));

   lcfg_config_top dut (
      .i_core_clk(clk), .i_reset(rst), .i_sleep_reset(slp), .i_spi_cs_n(cs_n), .i_spi_sck(sck),
      .i_spi_mosi(mosi), .o_spi_miso(miso), .i_lin_rx_data(lin), .i_sat_threshold(sat),
      .i_boost_above_threshold(bgood), .i_switch_fault_event(fev), .i_sync_shutdown(sds),
      .i_boost_shutdown(bos), .i_buck_shutdown(bus), .o_rxd(rxd), .o_slew_select(slew_o),
      .o_wave_shaping_off(wave), .o_lin_rate_10k4(rate), .o_sync_supply_on(sync_o), .o_boost_on(boost_o),
      .o_buck_on(buck_o), .o_charge_switch_on(chg_o), .o_discharge_switch_on(dis_o));

   always #5 clk = ~clk;

   // A hung handshake would stall the run, so the cycle count is capped.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Response word: opcode, odd parity bit, fixed status bits, data byte.
   function automatic logic [15:0] mk(input logic [1:0] op, input logic [7:0] b);
      return {1'b0, op, ^{op, b}, 4'hE, b};
   endfunction

   function automatic logic [7:0] lb();
      return {2'h0, 1'(mon), 2'(chan), 1'b0, 2'(slew)};
   endfunction

   function automatic logic [7:0] pb();
      return {bgood, 1'(flt), 1'(sync), 1'(boost_good_flag), 1'b0, 1'(bck), 2'(res)};
   endfunction

   // Compares every slew, supply and switch output with the model.
   task automatic look();
      chk("outputs", {7'h0, 2'(slew), 1'(slew >> 1), 1'(slew == 1), 1'(sync) & ~sds, 1'(boost_good_flag) & ~bos,
         1'(bck) & ~bus, 1'(res == 1), 1'(res == 2)},
         {7'h0, slew_o, wave, rate, sync_o, boost_o, buck_o, chg_o, dis_o});
   endtask

   // One frame; the reply carries the answer to the previous frame.
   task automatic frame(input logic [7:0] code, input logic [7:0] b, input int n);
      logic ok;
      ok = (n == 16) && (code inside {lcfg_pkg::LCFG_CODE_LIN_WR, lcfg_pkg::LCFG_CODE_LIN_RD,
         lcfg_pkg::LCFG_CODE_PWR_WR, lcfg_pkg::LCFG_CODE_PWR_RD});
      host.xfer({code, b}, n, resp);
      chk("response", exp_resp >> (16 - n), resp);
      if (ok && code == 8'h50) begin
         slew = b[1:0];
         chan = b[4:3];
         mon = b[5];
      end
      if (ok && code == 8'h51) begin
         sync = b[5];
         boost_good_flag = b[4];
         bck = b[2];
         res = b[1:0];
         flt = (b[1:0] == 2'h0) ? 0 : flt;
      end
      if (n != 16) begin
         exp_resp = mk(2'h0, 8'h04);
      end else if (!ok) begin
         exp_resp = mk(2'h0, 8'h02);
      end else begin
         exp_resp = mk(code[7] ? 2'h2 : 2'h1, code[0] ? pb() : lb());
      end
      look();
   endtask

   task automatic rst_all();
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      {slew, chan, mon, sync, flt} = 160'h0;
      {boost_good_flag, bck, res} = {32'h1, 32'h1, 32'h2};
      exp_resp = 16'h0000;
      repeat (2) @(negedge clk);
   endtask

   initial begin
      seed = 57;
      {clk, slp, lin, bgood, fev, sds, bos, bus, sat} = 12'h000;
      rst_all();
      look();
      frame(8'h90, 8'hFF, 16);
      // Random writes of the transceiver byte, each read back.
      for (int i = 0; i < 6; i++) begin
         frame(8'h50, 8'($random(seed)), 16);
         frame(8'h90, 8'($random(seed)), 16);
      end
      // Each satellite channel in turn, then plain receive data.
      for (int c = 0; c < 5; c++) begin
         frame(8'h50, {2'h0, 1'(c != 4), 2'(c), 3'h0}, 16);
         repeat (4) begin
            @(negedge clk);
            lin = 1'($random(seed));
            sat = 4'($random(seed));
            repeat (2) @(negedge clk);
            chk("rxd", 16'(c == 4 ? lin : sat[c]), 16'(rxd));
         end
      end
      // Every reserve code with random supply bits and boost level.
      for (int r = 0; r < 4; r++) begin
         bgood = 1'($random(seed));
         d = 8'($random(seed));
         frame(8'h51, {d[7:2], 2'(r)}, 16);
         frame(8'h91, d, 16);
      end
      // A switch fault survives a charge write and clears on 00.
      fev = 1'b1;
      @(negedge clk);
      fev = 1'b0;
      flt = 1;
      frame(8'h51, 8'h31, 16);
      frame(8'h51, 8'h34, 16);
      frame(8'h91, 8'h00, 16);
      // Shutdowns force supplies off while the enables read back on.
      {sds, bos, bus} = 3'h7;
      frame(8'h51, 8'h36, 16);
      frame(8'h91, 8'h00, 16);
      {sds, bos, bus} = 3'h0;
      // Sleep reset restores only the reserve field.
      frame(8'h50, 8'h03, 16);
      frame(8'h51, 8'h15, 16);
      slp = 1'b1;
      @(negedge clk);
      slp = 1'b0;
      res = 2;
      repeat (3) @(negedge clk);
      look();
      // A short frame and an unknown code change nothing.
      frame(8'h50, 8'h23, 15);
      frame(8'h52, 8'h00, 16);
      frame(8'h90, 8'h00, 16);
      // Internal reset in mid-run brings back every default.
      rst_all();
      look();
      frame(8'h91, 8'h00, 16);
      frame(8'h90, 8'h00, 16);
      results();
   end
endmodule
`default_nettype wire
